// file: hw/fssm_core.sv
module fssm_core
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic state_req_valid,
  input wire fssm_pkg::fssm_req_t state_req,
  input wire fssm_pkg::fssm_cfg_t cfg,
  input wire logic wd_enable,
  input wire logic [15:0] wd_mult,
  input wire logic [15:0] wd_time,
  input wire logic mbx_valid,
  input wire fssm_pkg::fssm_mbx_t mbx_kind,
  output logic mbx_accept,
  output logic mbx_reject,
  input wire logic pd_valid,
  input wire logic pd_out_valid,
  input wire logic [fssm_pkg::FSSM_DATA_W-1:0] pd_out_data,
  output logic pd_accept,
  output logic pd_reject,
  input wire logic [fssm_pkg::FSSM_DATA_W-1:0] phys_in,
  output logic [fssm_pkg::FSSM_DATA_W-1:0] dpm_in,
  output logic dpm_in_we,
  output logic [fssm_pkg::FSSM_DATA_W-1:0] phys_out,
  input wire logic od_valid,
  input wire fssm_pkg::fssm_od_req_t od_req,
  output logic od_ack,
  output logic od_err,
  output logic [fssm_pkg::FSSM_DATA_W-1:0] od_rdata,
  output logic [2:0] state,
  output logic state_ack,
  output logic err_flag,
  output fssm_pkg::fssm_err_t err_code,
  input wire logic err_clear,
  output logic wd_off,
  output logic wd_expired
);

  typedef enum {
    FSSM_INIT,
    FSSM_PREOP,
    FSSM_SAFEOP,
    FSSM_OP,
    FSSM_BOOT,
    FSSM_COPY
  } fssm_state_t;

  fssm_state_t cur;
  fssm_state_t next_cur;
  fssm_pkg::fssm_err_t next_err;
  logic next_fail;
  logic next_ack;
  logic [fssm_pkg::FSSM_DATA_W-1:0] chan_par [fssm_pkg::FSSM_CHAN_N];
  logic [fssm_pkg::FSSM_DATA_W-1:0] out_latch;
  logic [fssm_pkg::FSSM_DATA_W-1:0] in_sync1;
  logic [fssm_pkg::FSSM_DATA_W-1:0] in_sync2;
  logic wd_kick;
  logic out_live;
  logic chan_hit;
  logic od_writable;
  logic od_known;
  logic [2:0] chan_idx;

  function automatic logic od_page(input logic [15:0] index, input logic [3:0] page);
    od_page = (index[15:12] == page);
  endfunction

  fssm_watchdog u_wd
  (
    .clk(clk),
    .rst_b(rst_b),
    .enable(wd_enable),
    .mult(wd_mult),
    .wd_time(wd_time),
    .kick(wd_kick),
    .disabled(wd_off),
    .expired(wd_expired)
  );

  assign wd_kick = pd_valid && pd_accept;

  // any error code other than none is a failed check
  assign next_fail = (next_err != fssm_pkg::FSSM_ERR_NONE);

  // state transitions
  always_comb
  begin
    next_cur = cur;
    next_err = fssm_pkg::FSSM_ERR_NONE;
    next_ack = 1'b0;
    if (cur == FSSM_COPY)
    begin
      next_cur = FSSM_SAFEOP;
      next_ack = 1'b1;
    end
    else if (state_req_valid)
    begin
      case (state_req)
        fssm_pkg::FSSM_REQ_INIT:
        begin
          next_cur = FSSM_INIT;
          next_ack = 1'b1;
        end
        fssm_pkg::FSSM_REQ_PREOP:
        begin
          if (cur == FSSM_INIT && !cfg.mbx_ok)
            next_err = fssm_pkg::FSSM_ERR_MAILBOX;
          else if (cur == FSSM_BOOT)
            next_err = fssm_pkg::FSSM_ERR_ILLEGAL;
          else
          begin
            next_cur = FSSM_PREOP;
            next_ack = 1'b1;
          end
        end
        fssm_pkg::FSSM_REQ_SAFEOP:
        begin
          if (cur == FSSM_PREOP)
          begin
            if (!cfg.pd_ok)
              next_err = fssm_pkg::FSSM_ERR_PROCESS;
            else if (cfg.dc_used && !cfg.dc_ok)
              next_err = fssm_pkg::FSSM_ERR_CLOCK;
            else
              next_cur = FSSM_COPY;
          end
          else if (cur == FSSM_OP || cur == FSSM_SAFEOP)
          begin
            next_cur = FSSM_SAFEOP;
            next_ack = 1'b1;
          end
          else
            next_err = fssm_pkg::FSSM_ERR_ILLEGAL;
        end
        fssm_pkg::FSSM_REQ_OP:
        begin
          if ((cur == FSSM_SAFEOP || cur == FSSM_OP) && !wd_expired)
          begin
            next_cur = FSSM_OP;
            next_ack = 1'b1;
          end
          else
            next_err = wd_expired ? fssm_pkg::FSSM_ERR_WATCHDOG : fssm_pkg::FSSM_ERR_ILLEGAL;
        end
        fssm_pkg::FSSM_REQ_BOOT:
        begin
          if (cur == FSSM_INIT || cur == FSSM_BOOT)
          begin
            next_cur = FSSM_BOOT;
            next_ack = 1'b1;
          end
          else
            next_err = fssm_pkg::FSSM_ERR_BOOT;
        end
        default:
          next_err = fssm_pkg::FSSM_ERR_ILLEGAL;
      endcase
    end
    else if (cur == FSSM_OP && wd_expired)
    begin
      next_cur = FSSM_SAFEOP;
      next_err = fssm_pkg::FSSM_ERR_WATCHDOG;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cur <= FSSM_INIT;
      state_ack <= 1'b0;
    end
    else
    begin
      cur <= next_cur;
      state_ack <= next_ack;
    end
  end

  // sticky error, a new failure wins over the clear
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      err_flag <= 1'b0;
      err_code <= fssm_pkg::FSSM_ERR_NONE;
    end
    else if (next_fail)
    begin
      err_flag <= 1'b1;
      err_code <= next_err;
    end
    else if (err_clear)
    begin
      err_flag <= 1'b0;
      err_code <= fssm_pkg::FSSM_ERR_NONE;
    end
  end

  always_comb
  begin
    case (cur)
      FSSM_INIT: state = 3'h1;
      FSSM_PREOP: state = 3'h2;
      FSSM_BOOT: state = 3'h3;
      FSSM_SAFEOP: state = 3'h4;
      FSSM_COPY: state = 3'h2;
      FSSM_OP: state = 3'h5;
      default: state = 3'h1;
    endcase
  end

  // traffic gating per state
  always_comb
  begin
    mbx_accept = 1'b0;
    pd_accept = 1'b0;
    case (cur)
      FSSM_INIT: ;
      FSSM_PREOP: mbx_accept = mbx_valid;
      FSSM_COPY: mbx_accept = mbx_valid;
      FSSM_SAFEOP:
      begin
        mbx_accept = mbx_valid;
        pd_accept = pd_valid;
      end
      FSSM_OP:
      begin
        mbx_accept = mbx_valid;
        pd_accept = pd_valid;
      end
      FSSM_BOOT: mbx_accept = mbx_valid && (mbx_kind == fssm_pkg::FSSM_MBX_FILE);
      default: ;
    endcase
    mbx_reject = mbx_valid && !mbx_accept;
    pd_reject = pd_valid && !pd_accept;
  end

  // inputs from pins, copied into the input area
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      in_sync1 <= '0;
      in_sync2 <= '0;
    end
    else
    begin
      in_sync1 <= phys_in;
      in_sync2 <= in_sync1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      dpm_in <= '0;
      dpm_in_we <= 1'b0;
    end
    // write lands in the copy cycle, ahead of the acknowledge
    else if (next_cur == FSSM_COPY || cur == FSSM_COPY || cur == FSSM_SAFEOP || cur == FSSM_OP)
    begin
      dpm_in <= in_sync2;
      dpm_in_we <= 1'b1;
    end
    else
      dpm_in_we <= 1'b0;
  end

  // outputs: safe unless operational with the watchdog not expired, or watchdog switched off in safe operational
  assign out_live = (cur == FSSM_OP && !(wd_expired && !wd_off)) || (cur == FSSM_SAFEOP && wd_off);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      out_latch <= fssm_pkg::FSSM_OUT_SAFE;
    else if (pd_out_valid && pd_accept)
      out_latch <= pd_out_data;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      phys_out <= fssm_pkg::FSSM_OUT_SAFE;
    else if (out_live)
      phys_out <= out_latch;
    else
      phys_out <= fssm_pkg::FSSM_OUT_SAFE;
  end

  // object dictionary
  assign chan_hit = (od_page(od_req.index, fssm_pkg::FSSM_OD_PAGE_CHAN)
    || od_page(od_req.index, fssm_pkg::FSSM_OD_PAGE_LEGACY)) && (od_req.index[11:0] == 12'h000);
  assign chan_idx = od_req.subindex[2:0];
  assign od_writable = chan_hit && (od_req.subindex[7:3] == 5'h00);
  assign od_known = od_writable || od_page(od_req.index, fssm_pkg::FSSM_OD_PAGE_IDENT)
    || od_page(od_req.index, fssm_pkg::FSSM_OD_PAGE_INPUT) || od_page(od_req.index, fssm_pkg::FSSM_OD_PAGE_OUTPUT);

  generate
    for (genvar g = 0; g < fssm_pkg::FSSM_CHAN_N; g++)
    begin : g_chan
      always_ff @(posedge clk)
      begin
        if (!rst_b)
          chan_par[g] <= fssm_pkg::FSSM_CHAN_RESET;
        else if (od_valid && mbx_accept && od_req.write && od_writable && chan_idx == 3'(g))
          chan_par[g] <= od_req.wdata;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      od_ack <= 1'b0;
      od_err <= 1'b0;
      od_rdata <= '0;
    end
    else
    begin
      od_ack <= od_valid && mbx_accept;
      od_err <= od_valid && mbx_accept && (!od_known || (od_req.write && !od_writable));
      if (od_valid && mbx_accept)
      begin
        if (od_writable)
          od_rdata <= chan_par[chan_idx];
        else if (od_page(od_req.index, fssm_pkg::FSSM_OD_PAGE_IDENT))
          od_rdata <= fssm_pkg::FSSM_IDENT_VALUE;
        else if (od_page(od_req.index, fssm_pkg::FSSM_OD_PAGE_INPUT))
          od_rdata <= dpm_in;
        else if (od_page(od_req.index, fssm_pkg::FSSM_OD_PAGE_OUTPUT))
          od_rdata <= out_latch;
        else
          od_rdata <= '0;
      end
    end
  end

endmodule

// file: hw/fssm_pkg.sv
package fssm_pkg;

  typedef enum logic [2:0] {
    FSSM_REQ_INIT,
    FSSM_REQ_PREOP,
    FSSM_REQ_SAFEOP,
    FSSM_REQ_OP,
    FSSM_REQ_BOOT
  } fssm_req_t;

  typedef enum logic [2:0] {
    FSSM_ERR_NONE,
    FSSM_ERR_MAILBOX,
    FSSM_ERR_PROCESS,
    FSSM_ERR_CLOCK,
    FSSM_ERR_BOOT,
    FSSM_ERR_ILLEGAL,
    FSSM_ERR_WATCHDOG
  } fssm_err_t;

  typedef enum logic [1:0] {
    FSSM_MBX_PARAM,
    FSSM_MBX_FILE,
    FSSM_MBX_OTHER
  } fssm_mbx_t;

  localparam int FSSM_DATA_W = 16;
  localparam int FSSM_WD_W = 16;

  localparam logic [15:0] FSSM_OD_IDENT_BASE = 16'h1000;
  localparam logic [15:0] FSSM_OD_LEGACY_BASE = 16'h4000;
  localparam logic [15:0] FSSM_OD_INPUT_BASE = 16'h6000;
  localparam logic [15:0] FSSM_OD_OUTPUT_BASE = 16'h7000;
  localparam logic [15:0] FSSM_OD_CHAN_BASE = 16'h8000;
  localparam logic [3:0] FSSM_OD_PAGE_IDENT = 4'h1;
  localparam logic [3:0] FSSM_OD_PAGE_LEGACY = 4'h4;
  localparam logic [3:0] FSSM_OD_PAGE_INPUT = 4'h6;
  localparam logic [3:0] FSSM_OD_PAGE_OUTPUT = 4'h7;
  localparam logic [3:0] FSSM_OD_PAGE_CHAN = 4'h8;
  localparam int FSSM_CHAN_N = 8;
  localparam logic [FSSM_DATA_W-1:0] FSSM_CHAN_RESET = 16'h0000;
  localparam logic [FSSM_DATA_W-1:0] FSSM_OUT_SAFE = 16'h0000;
  localparam logic [FSSM_DATA_W-1:0] FSSM_IDENT_VALUE = 16'h5a5a;

  localparam int FSSM_CLK_MHZ = 125;
  localparam int FSSM_REF_MHZ = 25;
  localparam int FSSM_BASE_TICK_NS = 40;
  localparam int FSSM_CLK_NS = 1000 / FSSM_CLK_MHZ;
  localparam int FSSM_BASE_TICK_CYC = (FSSM_BASE_TICK_NS + FSSM_CLK_NS - 1) / FSSM_CLK_NS;
  localparam logic [15:0] FSSM_WD_MULT_RESET = 16'h09c2;
  localparam logic [15:0] FSSM_WD_TIME_RESET = 16'h03e8;
  localparam logic [15:0] FSSM_WD_MULT_ADD = 16'h0002;

  typedef struct packed {
    logic [15:0] index;
    logic [7:0] subindex;
    logic write;
    logic [FSSM_DATA_W-1:0] wdata;
  } fssm_od_req_t;

  typedef struct packed {
    logic mbx_ok;
    logic pd_ok;
    logic dc_ok;
    logic dc_used;
  } fssm_cfg_t;

endpackage

// file: hw/fssm_watchdog.sv
module fssm_watchdog
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic [15:0] mult,
  input wire logic [15:0] wd_time,
  input wire logic kick,
  output logic disabled,
  output logic expired
);

  logic [2:0] base_cnt;
  logic [15:0] tick_cnt;
  logic [15:0] wd_cnt;
  logic base_pulse;
  logic tick_pulse;

  assign disabled = (wd_time == 16'h0000);
  assign base_pulse = (base_cnt == 3'(fssm_pkg::FSSM_BASE_TICK_CYC - 1));
  assign tick_pulse = base_pulse && (tick_cnt == 16'(mult + fssm_pkg::FSSM_WD_MULT_ADD - 16'h0001));

  // 40 ns base tick from the system clock
  always_ff @(posedge clk)
  begin
    if (!rst_b || kick || !enable)
      base_cnt <= 3'h0;
    else if (base_pulse)
      base_cnt <= 3'h0;
    else
      base_cnt <= base_cnt + 3'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b || kick || !enable)
      tick_cnt <= 16'h0000;
    else if (tick_pulse)
      tick_cnt <= 16'h0000;
    else if (base_pulse)
      tick_cnt <= tick_cnt + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b || kick || !enable || disabled)
    begin
      wd_cnt <= 16'h0000;
      expired <= 1'b0;
    end
    else if (tick_pulse && !expired)
    begin
      if (wd_cnt == 16'(wd_time - 16'h0001))
        expired <= 1'b1;
      else
        wd_cnt <= wd_cnt + 16'h0001;
    end
  end

endmodule

// file: verification/fssm_core_sva.sv
module fssm_core_sva
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic state_req_valid,
  input wire fssm_pkg::fssm_req_t state_req,
  input wire fssm_pkg::fssm_cfg_t cfg,
  input wire logic [15:0] wd_time,
  input wire logic mbx_valid,
  input wire fssm_pkg::fssm_mbx_t mbx_kind,
  input wire logic mbx_accept,
  input wire logic mbx_reject,
  input wire logic pd_valid,
  input wire logic pd_accept,
  input wire logic pd_reject,
  input wire logic dpm_in_we,
  input wire logic [fssm_pkg::FSSM_DATA_W-1:0] phys_out,
  input wire logic od_valid,
  input wire fssm_pkg::fssm_od_req_t od_req,
  input wire logic od_err,
  input wire logic [2:0] state,
  input wire logic state_ack,
  input wire logic err_flag,
  input wire fssm_pkg::fssm_err_t err_code,
  input wire logic wd_off
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_wd_off;
    wd_off == (wd_time == 16'h0000);
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("watchdog off flag wrong");
  property p_state_range;
    state inside {[3'h1:3'h5]};
  endproperty
  a_state_range: assert property (p_state_range) else $error("state code out of range");
  property p_init_refuse;
    mbx_valid && state == 3'h1 |-> mbx_reject && !mbx_accept;
  endproperty
  a_init_refuse: assert property (p_init_refuse) else $error("mailbox passed in init");
  property p_preop_pd;
    pd_valid && state == 3'h2 |-> pd_reject && !pd_accept;
  endproperty
  a_preop_pd: assert property (p_preop_pd) else $error("process data passed in preop");
  property p_boot_mbx;
    mbx_valid && state == 3'h3 && mbx_kind != fssm_pkg::FSSM_MBX_FILE |-> mbx_reject;
  endproperty
  a_boot_mbx: assert property (p_boot_mbx) else $error("non file mailbox passed in boot");
  property p_boot_refuse;
    state_req_valid && state_req == fssm_pkg::FSSM_REQ_BOOT && state inside {3'h4, 3'h5}
      |=> err_code == fssm_pkg::FSSM_ERR_BOOT && state != 3'h3;
  endproperty
  a_boot_refuse: assert property (p_boot_refuse) else $error("boot taken from run state");
  property p_mbx_check;
    state_req_valid && state_req == fssm_pkg::FSSM_REQ_PREOP && state == 3'h1 && !cfg.mbx_ok
      |=> err_flag && err_code == fssm_pkg::FSSM_ERR_MAILBOX && state == 3'h1;
  endproperty
  a_mbx_check: assert property (p_mbx_check) else $error("preop taken without mailbox");
  property p_copy;
    state_req_valid && state_req == fssm_pkg::FSSM_REQ_SAFEOP && state == 3'h2 && !dpm_in_we
      && cfg.pd_ok && (!cfg.dc_used || cfg.dc_ok) |=> dpm_in_we && state == 3'h2 ##1 state_ack && state == 3'h4;
  endproperty
  a_copy: assert property (p_copy) else $error("safeop entry without copy");
  property p_safe_out;
    state == 3'h4 && !wd_off |=> phys_out == fssm_pkg::FSSM_OUT_SAFE;
  endproperty
  a_safe_out: assert property (p_safe_out) else $error("outputs live in safeop");
  property p_ro_write;
    od_valid && mbx_accept && od_req.write && od_req.index[15:12] == 4'h1 |=> od_err;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("identity write not refused");
endmodule

bind fssm_core fssm_core_sva i_fssm_core_sva (.clk, .rst_b, .state_req_valid, .state_req, .cfg, .wd_time,
  .mbx_valid, .mbx_kind, .mbx_accept, .mbx_reject, .pd_valid, .pd_accept, .pd_reject, .dpm_in_we, .phys_out,
  .od_valid, .od_req, .od_err, .state, .state_ack, .err_flag, .err_code, .wd_off);

// file: verification/fssm_master_model.sv
module fssm_master_model
(
  input wire logic mbx_set,
  input wire logic pd_set,
  input wire logic dc_set,
  input wire logic dc_use,
  input wire logic frame,
  input wire logic [15:0] out_val,
  output fssm_pkg::fssm_cfg_t cfg,
  output logic pd_out_valid,
  output logic [15:0] pd_out_data
);
  timeunit 1ns;
  timeprecision 1ps;
  assign cfg = '{mbx_ok: mbx_set, pd_ok: pd_set, dc_ok: dc_set, dc_used: dc_use};
  assign pd_out_valid = frame;
  // data line not held outside a frame
  assign pd_out_data = frame ? out_val : ~out_val;
endmodule

// file: verification/tb_fssm_core.sv
module tb_fssm_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, state_req_valid = 0, wd_enable = 1, mbx_valid = 0, pd_valid = 0;
  logic od_valid = 0, err_clear = 0, mbx_set = 0, pd_set = 0, dc_set = 0, dc_use = 0;
  fssm_pkg::fssm_req_t state_req = fssm_pkg::FSSM_REQ_INIT;
  fssm_pkg::fssm_mbx_t mbx_kind = fssm_pkg::FSSM_MBX_PARAM;
  fssm_pkg::fssm_od_req_t od_req = '0;
  logic [15:0] wd_mult = 16'h0000, wd_time = 16'h0010, phys_in = 16'h0000, out_val = 16'h0000;
  fssm_pkg::fssm_cfg_t cfg;
  fssm_pkg::fssm_err_t err_code;
  logic pd_out_valid, mbx_accept, mbx_reject, pd_accept, pd_reject, dpm_in_we, od_ack, od_err;
  logic state_ack, err_flag, wd_off, wd_expired;
  logic [15:0] pd_out_data, dpm_in, phys_out, od_rdata;
  logic [2:0] state;
  int num_errors = 0, check_count = 0;
  fssm_master_model i_fssm_master_model (.mbx_set, .pd_set, .dc_set, .dc_use, .frame(pd_valid), .out_val,
    .cfg, .pd_out_valid, .pd_out_data);
  fssm_core i_fssm_core (.clk, .rst_b, .state_req_valid, .state_req, .cfg, .wd_enable, .wd_mult, .wd_time,
    .mbx_valid, .mbx_kind, .mbx_accept, .mbx_reject, .pd_valid, .pd_out_valid, .pd_out_data, .pd_accept,
    .pd_reject, .phys_in, .dpm_in, .dpm_in_we, .phys_out, .od_valid, .od_req, .od_ack, .od_err, .od_rdata,
    .state, .state_ack, .err_flag, .err_code, .err_clear, .wd_off, .wd_expired);
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic req(input fssm_pkg::fssm_req_t k);
    @(negedge clk);
    state_req = k;
    state_req_valid = 1;
    @(negedge clk);
    state_req_valid = 0;
  endtask
  task automatic clr;
    @(negedge clk);
    err_clear = 1;
    @(negedge clk);
    err_clear = 0;
  endtask
  task automatic mbx(input fssm_pkg::fssm_mbx_t k, input logic e);
    @(negedge clk);
    mbx_valid = 1;
    mbx_kind = k;
    #1 chk(mbx_accept, e);
    chk(mbx_reject, !e);
    @(negedge clk);
    mbx_valid = 0;
  endtask
  task automatic pd(input logic e);
    @(negedge clk);
    pd_valid = 1;
    #1 chk(pd_accept, e);
    chk(pd_reject, !e);
    @(negedge clk);
    pd_valid = 0;
  endtask
  task automatic od(input logic [15:0] i, input logic [7:0] s, input logic w, input logic [15:0] d,
    input logic e, input logic [15:0] r);
    @(negedge clk);
    od_valid = 1;
    mbx_valid = 1;
    mbx_kind = fssm_pkg::FSSM_MBX_PARAM;
    od_req = '{index: i, subindex: s, write: w, wdata: d};
    @(negedge clk);
    od_valid = 0;
    mbx_valid = 0;
    chk(od_ack, 1'b1);
    chk(od_err, e);
    if (!w && !e)
      chk(od_rdata, r);
  endtask
  task automatic t_init;
    chk(state, 16'h0001);
    mbx(fssm_pkg::FSSM_MBX_PARAM, 1'b0);
    pd(1'b0);
  endtask
  task automatic t_preop;
    req(fssm_pkg::FSSM_REQ_PREOP);
    chk(err_code, fssm_pkg::FSSM_ERR_MAILBOX);
    chk(state, 16'h0001);
    clr;
    chk(err_flag, 1'b0);
    mbx_set = 1;
    req(fssm_pkg::FSSM_REQ_PREOP);
    chk(state_ack, 1'b1);
    chk(state, 16'h0002);
    mbx(fssm_pkg::FSSM_MBX_PARAM, 1'b1);
    pd(1'b0);
  endtask
  task automatic t_boot;
    req(fssm_pkg::FSSM_REQ_BOOT);
    chk(err_code, fssm_pkg::FSSM_ERR_BOOT);
    chk(state, 16'h0002);
    clr;
    req(fssm_pkg::FSSM_REQ_INIT);
    req(fssm_pkg::FSSM_REQ_BOOT);
    chk(state, 16'h0003);
    mbx(fssm_pkg::FSSM_MBX_FILE, 1'b1);
    mbx(fssm_pkg::FSSM_MBX_PARAM, 1'b0);
    mbx(fssm_pkg::FSSM_MBX_OTHER, 1'b0);
    pd(1'b0);
    req(fssm_pkg::FSSM_REQ_PREOP);
    chk(err_code, fssm_pkg::FSSM_ERR_ILLEGAL);
    clr;
    req(fssm_pkg::FSSM_REQ_INIT);
    req(fssm_pkg::FSSM_REQ_PREOP);
    chk(state, 16'h0002);
  endtask
  task automatic t_od;
    od(16'h8000, 8'h03, 1'b1, 16'h1234, 1'b0, 16'h0000);
    od(16'h4000, 8'h03, 1'b0, 16'h0000, 1'b0, 16'h1234);
    od(16'h4000, 8'h05, 1'b1, 16'habcd, 1'b0, 16'h0000);
    od(16'h8000, 8'h05, 1'b0, 16'h0000, 1'b0, 16'habcd);
    od(16'h1000, 8'h00, 1'b0, 16'h0000, 1'b0, fssm_pkg::FSSM_IDENT_VALUE);
    od(16'h1018, 8'h01, 1'b1, 16'h0001, 1'b1, 16'h0000);
    od(16'h7000, 8'h00, 1'b1, 16'h0001, 1'b1, 16'h0000);
    od(16'hffff, 8'hff, 1'b0, 16'h0000, 1'b1, 16'h0000);
  endtask
  task automatic t_safeop;
    phys_in = 16'h00a5;
    req(fssm_pkg::FSSM_REQ_SAFEOP);
    chk(err_code, fssm_pkg::FSSM_ERR_PROCESS);
    clr;
    pd_set = 1;
    dc_use = 1;
    req(fssm_pkg::FSSM_REQ_SAFEOP);
    chk(err_code, fssm_pkg::FSSM_ERR_CLOCK);
    clr;
    dc_set = 1;
    req(fssm_pkg::FSSM_REQ_SAFEOP);
    chk(dpm_in_we, 1'b1);
    chk(state, 16'h0002);
    @(negedge clk);
    chk(state_ack, 1'b1);
    chk(state, 16'h0004);
    chk(dpm_in, 16'h00a5);
    mbx(fssm_pkg::FSSM_MBX_PARAM, 1'b1);
    out_val = 16'h3c3c;
    phys_in = 16'h005a;
    pd(1'b1);
    repeat (4) @(negedge clk);
    chk(phys_out, fssm_pkg::FSSM_OUT_SAFE);
    chk(dpm_in, 16'h005a);
    wd_time = 16'h0000;
    pd(1'b1);
    repeat (3) @(negedge clk);
    chk(wd_off, 1'b1);
    chk(phys_out, 16'h3c3c);
    wd_time = 16'h0010;
    repeat (3) @(negedge clk);
    chk(phys_out, fssm_pkg::FSSM_OUT_SAFE);
  endtask
  task automatic t_op;
    int n;
    out_val = 16'hc3c3;
    pd(1'b1);
    req(fssm_pkg::FSSM_REQ_OP);
    chk(state_ack, 1'b1);
    chk(state, 16'h0005);
    repeat (2) @(negedge clk);
    chk(phys_out, 16'hc3c3);
    req(fssm_pkg::FSSM_REQ_BOOT);
    chk(err_code, fssm_pkg::FSSM_ERR_BOOT);
    chk(state, 16'h0005);
    clr;
    mbx(fssm_pkg::FSSM_MBX_PARAM, 1'b1);
    pd(1'b1);
    // expiry after 16 * (0 + 2) ticks of 5 cycles
    for (n = 0; n < 400 && wd_expired !== 1'b1; n++)
      @(negedge clk);
    chk(n >= 150 && n <= 165, 1'b1);
    repeat (2) @(negedge clk);
    chk(state, 16'h0004);
    chk(err_code, fssm_pkg::FSSM_ERR_WATCHDOG);
    chk(phys_out, fssm_pkg::FSSM_OUT_SAFE);
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    rst_b = 1;
    t_init;
    t_preop;
    t_boot;
    t_od;
    t_safeop;
    t_op;
    close_out;
  end
  initial
  begin
    #200000;
    num_errors++;
    close_out;
  end
endmodule
